// ### rtl/bmfc_top.sv
// Overview of operation
// - Mode change during a serial frame aborts it and discards its bits.
// - Entering brake keeps the serial command data unchanged.
// - After brake release only the second frame's data takes effect.
// - Entering standby clears all serially configured data.
// - Frames sent during standby are not accepted.
// - Off-to-on switching holds the half-bridge off for about one microsecond.
// - Both sides commanded on gives an off half-bridge.
// - Undervoltage resets all state except pin synchronisers and fault filters, and turns every output off.
// - Every fault detect and release signal is filtered against chatter.
// - Bridge overvoltage forces all outputs off and sets status bit 15.
// - Outputs resume from stored data once overvoltage ends; flag stays.
// - Overvoltage flag clears by full status reset or bit 15.
// - Overcurrent in a driver turns it off and sets status bit 13.
// - Overcurrent shutdown stays latched until cleared by frame.
// - Bits 0 and 15 reset flags, turn outputs off, ignore bits 1-12.
// - Bit 13 clears overcurrent and applies bits 1-12 at once.
// - A persisting fault is detected again after its flag clears.
// - Overtemperature forces outputs off and sets bit 14; flag stays.
// - Overtemperature flag clears by bit 14 or full status reset.
// - The internal clock runs logic, dead time and fault detection.
// - In standby only undervoltage detection operates.
// - Frame starts at select fall; out on rising, in on falling clock.
// - Mode low: select high brakes except from standby, select low enters standby.
// - Status bits 1-12 report each transistor's on state.
`timescale 1ns/1ps
module bmfc_top
    import bmfc_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [APB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Serial link
    input  wire logic                  linkClk,
    input  wire logic                  linkSelectN,
    input  wire logic                  linkDataIn,
    output logic                       linkDataOut,
    output logic                       linkDataOutEn,
    // Mode pins
    input  wire logic                  modePin,
    input  wire logic                  modeSelectPin,
    // Analog detector results
    input  wire logic                  uvDetect,
    input  wire logic                  bridgeASupplyHigh,
    input  wire logic                  overTempDetect,
    input  wire logic [TR_COUNT-1:0]   overCurrentDetect,
    // Bridge gate commands
    output logic      [HB_COUNT-1:0]   highSideOn,
    output logic      [HB_COUNT-1:0]   lowSideOn
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [4:0]                 syncA;
        logic [4:0]                 syncB;
        logic                       sclkPrev;
        logic                       selPrev;
        bmfc_mode_t                 mode;
        logic                       inFrame;
        logic                       aborted;
        logic                       postBrake;
        logic [4:0]                 bitCnt;
        logic [15:0]                rxShift;
        logic [15:0]                txShift;
        logic                       dout;
        logic                       doutEn;
        logic [TR_COUNT-1:0]        cmd;
        logic [TR_COUNT-1:0]        ocLatch;
        logic                       overcurrentFlag;
        logic                       overtemperatureFlag;
        logic                       overvoltageFlag;
        logic [TR_COUNT-1:0]        outputPowerTransistorOn;
        logic [HB_COUNT-1:0][7:0]   dtCnt;
        logic [7:0]                 deadCfg;
        logic                       pready;
        logic                       pslverr;
        logic [31:0]                prdata;
    } bmfc_state_t;

    localparam bmfc_state_t ST_INIT = '{
        mode    : MODE_STANDBY,
        deadCfg : DEAD_CYCLES,
        default : '0
    };

    bmfc_state_t         st_r;
    bmfc_state_t         st_nxt;

    logic                uvFilt;
    logic                ovFilt;
    logic                otFilt;
    logic [TR_COUNT-1:0] ocFilt;
    logic                detHold;
    logic                sclkNow;
    logic                selNow;
    logic                dinNow;
    logic                modeNow;
    logic                msNow;
    logic                sclkRise;
    logic                sclkFall;
    logic                selFall;
    logic                selRise;
    logic                modeChange;
    logic                brakeRelease;
    logic                frameDone;
    logic                applyCmd;
    logic                statusReset;
    logic                allOff;
    logic [15:0]         statusWord;
    logic [TR_COUNT-1:0] want;
    logic [1:0]          hbWant;
    logic [1:0]          hbOut;
    logic                apbAccess;
    logic                apbWrite;

    // ------------------------------------------------------------------------
    // Fault filters
    // ------------------------------------------------------------------------
    // Detection is held idle in standby and during undervoltage
    assign detHold = (st_r.mode == MODE_STANDBY) || uvFilt;

    bmfc_filter u_uvFilt (
        .clk     (clk),
        .arst_n  (arst_n),
        .hold    (1'b0),
        .rawIn   (uvDetect),
        .filtOut (uvFilt)
    );

    bmfc_filter u_ovFilt (
        .clk     (clk),
        .arst_n  (arst_n),
        .hold    (detHold),
        .rawIn   (bridgeASupplyHigh),
        .filtOut (ovFilt)
    );

    bmfc_filter u_otFilt (
        .clk     (clk),
        .arst_n  (arst_n),
        .hold    (detHold),
        .rawIn   (overTempDetect),
        .filtOut (otFilt)
    );

    for (genvar g = 0; g < TR_COUNT; g++) begin : g_ocFilt
        bmfc_filter u_ocFilt (
            .clk     (clk),
            .arst_n  (arst_n),
            .hold    (detHold),
            .rawIn   (overCurrentDetect[g]),
            .filtOut (ocFilt[g])
        );
    end

    // ------------------------------------------------------------------------
    // Pin edges and status word
    // ------------------------------------------------------------------------
    // Second synchroniser stage feeds all pin logic
    assign sclkNow  = st_r.syncB[4];
    assign selNow   = st_r.syncB[3];
    assign dinNow   = st_r.syncB[2];
    assign modeNow  = st_r.syncB[1];
    assign msNow    = st_r.syncB[0];
    assign sclkRise = sclkNow & ~st_r.sclkPrev;
    assign sclkFall = ~sclkNow & st_r.sclkPrev;
    assign selFall  = ~selNow & st_r.selPrev;
    assign selRise  = selNow & ~st_r.selPrev;

    // Flags on top, live transistor states below, bit 0 reads low
    assign statusWord = {st_r.overvoltageFlag, st_r.overtemperatureFlag,
                         st_r.overcurrentFlag, st_r.outputPowerTransistorOn, 1'b0};

    // APB access phase and write strobe
    assign apbAccess = psel && penable && !st_r.pready;
    assign apbWrite  = psel && penable && st_r.pready && pwrite;

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    always_comb begin
        st_nxt       = st_r;
        frameDone    = 1'b0;
        applyCmd     = 1'b0;
        statusReset  = 1'b0;
        allOff       = 1'b0;
        want         = '0;
        hbWant       = 2'b00;
        hbOut        = 2'b00;
        brakeRelease = 1'b0;

        // Pin synchronisers and edge history
        st_nxt.syncA    = {linkClk, linkSelectN, linkDataIn, modePin, modeSelectPin};
        st_nxt.syncB    = st_r.syncA;
        st_nxt.sclkPrev = sclkNow;
        st_nxt.selPrev  = selNow;

        // Mode selection; standby leaves only through normal
        unique case (st_r.mode)
            MODE_NORMAL: begin
                if (!modeNow) begin
                    st_nxt.mode = msNow ? MODE_BRAKE : MODE_STANDBY;
                end
            end
            MODE_BRAKE: begin
                if (modeNow) begin
                    st_nxt.mode  = MODE_NORMAL;
                    brakeRelease = 1'b1;
                end else if (!msNow) begin
                    st_nxt.mode = MODE_STANDBY;
                end
            end
            MODE_STANDBY: begin
                if (modeNow) begin
                    st_nxt.mode = MODE_NORMAL;
                end
            end
            default: begin
                st_nxt.mode = MODE_STANDBY;
            end
        endcase
        modeChange = (st_nxt.mode != st_r.mode);

        // Serial frame: shift out on rising, capture on falling
        if (selFall) begin
            st_nxt.inFrame = 1'b1;
            st_nxt.aborted = 1'b0;
            st_nxt.bitCnt  = 5'h00;
            st_nxt.rxShift = 16'h0000;
            st_nxt.txShift = statusWord;
            st_nxt.dout    = 1'b0;
        end else if (st_r.inFrame) begin
            if (sclkRise) begin
                st_nxt.dout    = st_r.txShift[15];
                st_nxt.txShift = {st_r.txShift[14:0], 1'b0};
            end
            if (sclkFall && st_r.bitCnt != BIT_CNT_MAX) begin
                st_nxt.rxShift = {st_r.rxShift[14:0], dinNow};
                st_nxt.bitCnt  = st_r.bitCnt + 5'h01;
            end
            if (selRise) begin
                st_nxt.inFrame = 1'b0;
                frameDone      = !st_r.aborted && !modeChange && (st_r.bitCnt == FRAME_BITS)
                                 && (st_r.mode == MODE_NORMAL);
            end
        end
        if (modeChange) begin
            st_nxt.aborted = 1'b1;
        end
        st_nxt.doutEn = ~selNow && (st_r.mode != MODE_STANDBY);

        // A frame cut by the release counts as the first one after it
        if (brakeRelease) begin
            st_nxt.postBrake = !st_r.inFrame;
        end
        if (frameDone && st_r.postBrake) begin
            st_nxt.postBrake = 1'b0;
        end
        applyCmd    = frameDone && !st_r.postBrake;
        statusReset = applyCmd && st_r.rxShift[STATUS_RST_BIT] && st_r.rxShift[OV_BIT];

        // Frame effects on command data and flags
        if (statusReset) begin
            st_nxt.cmd                 = '0;
            st_nxt.ocLatch             = '0;
            st_nxt.overcurrentFlag     = 1'b0;
            st_nxt.overtemperatureFlag = 1'b0;
            st_nxt.overvoltageFlag     = 1'b0;
        end else if (applyCmd) begin
            st_nxt.cmd = st_r.rxShift[CMD_MSB:CMD_LSB];
            if (st_r.rxShift[OC_BIT]) begin
                st_nxt.ocLatch         = '0;
                st_nxt.overcurrentFlag = 1'b0;
            end
            if (st_r.rxShift[OT_BIT]) begin
                st_nxt.overtemperatureFlag = 1'b0;
            end
            if (st_r.rxShift[OV_BIT]) begin
                st_nxt.overvoltageFlag = 1'b0;
            end
        end

        // Filtered detections set flags; a set beats a same-cycle clear
        if (ovFilt) begin
            st_nxt.overvoltageFlag = 1'b1;
        end
        if (otFilt) begin
            st_nxt.overtemperatureFlag = 1'b1;
        end
        if (ocFilt != '0) begin
            st_nxt.overcurrentFlag = 1'b1;
        end
        st_nxt.ocLatch = st_nxt.ocLatch | ocFilt;

        // Standby drops everything the link configured
        if (st_r.mode == MODE_STANDBY) begin
            st_nxt.cmd                 = '0;
            st_nxt.ocLatch             = '0;
            st_nxt.overcurrentFlag     = 1'b0;
            st_nxt.overtemperatureFlag = 1'b0;
            st_nxt.overvoltageFlag     = 1'b0;
            st_nxt.postBrake           = 1'b0;
        end

        // Wanted transistor states; brake keeps cmd untouched
        allOff = ovFilt || otFilt || (st_r.mode == MODE_STANDBY);
        for (int k = 0; k < HB_COUNT; k++) begin
            if (st_r.mode == MODE_BRAKE) begin
                hbWant = 2'b10;
            end else if (st_r.cmd[2*k] && st_r.cmd[2*k+1]) begin
                hbWant = 2'b00;
            end else begin
                hbWant = {st_r.cmd[2*k+1], st_r.cmd[2*k]};
            end
            if (allOff) begin
                hbWant = 2'b00;
            end
            want[2*k +: 2] = hbWant & ~(st_r.ocLatch[2*k +: 2] | ocFilt[2*k +: 2]);
        end

        // Dead time: any turn-on first holds the half-bridge off
        for (int k = 0; k < HB_COUNT; k++) begin
            hbWant = want[2*k +: 2];
            hbOut  = st_r.outputPowerTransistorOn[2*k +: 2];
            if (st_r.dtCnt[k] == 8'h00) begin
                if ((hbWant & ~hbOut) != 2'b00) begin
                    st_nxt.outputPowerTransistorOn[2*k +: 2] = 2'b00;
                    st_nxt.dtCnt[k]                          = st_r.deadCfg;
                end else begin
                    st_nxt.outputPowerTransistorOn[2*k +: 2] = hbWant;
                end
            end else if (st_r.dtCnt[k] == 8'h01) begin
                st_nxt.outputPowerTransistorOn[2*k +: 2] = hbWant;
                st_nxt.dtCnt[k]                          = 8'h00;
            end else begin
                st_nxt.outputPowerTransistorOn[2*k +: 2] = 2'b00;
                st_nxt.dtCnt[k]                          = st_r.dtCnt[k] - 8'h01;
            end
        end

        // APB slave: one wait state, then data with pready
        st_nxt.pready  = 1'b0;
        st_nxt.pslverr = 1'b0;
        st_nxt.prdata  = 32'h0000_0000;
        if (apbAccess) begin
            st_nxt.pready = 1'b1;
            case (paddr)
                REG_STATUS: st_nxt.prdata = {14'h0000, st_r.mode, statusWord};
                REG_CMD:    st_nxt.prdata = {8'h00, st_r.ocLatch, st_r.cmd};
                REG_DEAD:   st_nxt.prdata = {24'h00_0000, st_r.deadCfg};
                default:    st_nxt.pslverr = 1'b1;
            endcase
        end
        if (apbWrite && paddr == REG_DEAD) begin
            st_nxt.deadCfg = (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
        end

        // Undervoltage returns all but the pin synchronisers and edge history to the initial state
        if (uvFilt) begin
            st_nxt          = ST_INIT;
            st_nxt.syncA    = {linkClk, linkSelectN, linkDataIn, modePin, modeSelectPin};
            st_nxt.syncB    = st_r.syncA;
            st_nxt.sclkPrev = sclkNow;
            st_nxt.selPrev  = selNow;
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    // Single clock runs link, dead time and fault logic
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= ST_INIT;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign prdata        = st_r.prdata;
    assign pready        = st_r.pready;
    assign pslverr       = st_r.pslverr;
    assign linkDataOut   = st_r.dout;
    assign linkDataOutEn = st_r.doutEn;

    for (genvar h = 0; h < HB_COUNT; h++) begin : g_gate
        assign highSideOn[h] = st_r.outputPowerTransistorOn[2*h];
        assign lowSideOn[h]  = st_r.outputPowerTransistorOn[2*h+1];
    end

endmodule

// ### rtl/bmfc_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants for the bridge mode and fault control block
// ----------------------------------------------------------------------------
package bmfc_pkg;

    // Clock rate and dead-time figures
    localparam int         CLK_PERIOD_NS = 100;
    localparam int         DEAD_TIME_NS  = 1000;
    localparam int         DEAD_CYCLES_I = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] DEAD_CYCLES   = DEAD_CYCLES_I[7:0];

    // Samples a fault input must stay stable before the filter follows it
    localparam int         FILTER_CYCLES = 4;

    // Serial frame layout
    localparam logic [4:0] FRAME_BITS    = 5'h10;
    localparam logic [4:0] BIT_CNT_MAX   = 5'h1F;
    localparam int         STATUS_RST_BIT = 0;
    localparam int         CMD_LSB       = 1;
    localparam int         CMD_MSB       = 12;
    localparam int         OC_BIT        = 13;
    localparam int         OT_BIT        = 14;
    localparam int         OV_BIT        = 15;

    // Bridge geometry
    localparam int         HB_COUNT      = 6;
    localparam int         TR_COUNT      = 12;

    // APB register map
    localparam int         APB_ADDR_W    = 8;
    localparam logic [7:0] REG_STATUS    = 8'h00;
    localparam logic [7:0] REG_CMD       = 8'h04;
    localparam logic [7:0] REG_DEAD      = 8'h08;

    // Operating modes
    typedef enum logic [1:0] {
        MODE_NORMAL  = 2'b00,
        MODE_BRAKE   = 2'b01,
        MODE_STANDBY = 2'b10
    } bmfc_mode_t;

endpackage

// ### rtl/bmfc_filter.sv
`timescale 1ns/1ps
module bmfc_filter
    import bmfc_pkg::*;
#(
    parameter int LEN = FILTER_CYCLES
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic hold,
    input  wire logic rawIn,
    output logic      filtOut
);

    // ------------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------------
    if (LEN < 1 || LEN > 15) begin : g_len_check
        $error("bmfc_filter: LEN must lie in 1..15");
    end

    localparam logic [3:0] LEN_M1 = 4'(LEN - 1);

    typedef struct packed {
        logic       s1;
        logic       s2;
        logic       out;
        logic [3:0] cnt;
    } bmfc_filt_t;

    bmfc_filt_t st_r;
    bmfc_filt_t st_nxt;

    // Synchronise, then follow the input only after it stays stable
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = rawIn;
        st_nxt.s2 = st_r.s1;
        if (hold) begin
            st_nxt.cnt = 4'h0;
            st_nxt.out = 1'b0;
        end else if (st_r.s2 == st_r.out) begin
            st_nxt.cnt = 4'h0;
        end else if (st_r.cnt == LEN_M1) begin
            st_nxt.cnt = 4'h0;
            st_nxt.out = st_r.s2;
        end else begin
            st_nxt.cnt = st_r.cnt + 4'h1;
        end
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign filtOut = st_r.out;

endmodule

// ### verification/bmfc_chk.sv
`timescale 1ns/1ps
module bmfc_chk
    import bmfc_pkg::*;
(
    input wire logic                clk,
    input wire logic                arst_n,
    input wire logic                modePin,
    input wire logic                modeSelectPin,
    input wire logic                uvDetect,
    input wire logic                bridgeASupplyHigh,
    input wire logic                overTempDetect,
    input wire logic                linkSelectN,
    input wire logic                linkDataOutEn,
    input wire logic [HB_COUNT-1:0] highSideOn,
    input wire logic [HB_COUNT-1:0] lowSideOn
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // All gates quiet, and time half-bridge 0 has spent quiet
    logic       allOff;
    logic [7:0] offCnt_r;
    assign allOff = ((highSideOn | lowSideOn) == '0);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            offCnt_r <= 8'h00;
        end else if (highSideOn[0] || lowSideOn[0]) begin
            offCnt_r <= 8'h00;
        end else if (offCnt_r != 8'hFF) begin
            offCnt_r <= offCnt_r + 8'h01;
        end
    end
    a_gates_exclusive: assert property ((highSideOn & lowSideOn) == '0)
        else $error("both gates of a half-bridge on");
    a_dead_time: assert property (
        ($rose(highSideOn[0]) || $rose(lowSideOn[0])) |-> offCnt_r >= 8'h09)
        else $error("gate turned on before dead time ended");
    a_standby_quiet: assert property (
        (!modePin && !modeSelectPin) [*6] |-> allOff && !linkDataOutEn)
        else $error("outputs active in standby");
    a_brake_high_off: assert property (
        (!modePin && modeSelectPin) [*6] |-> highSideOn == '0)
        else $error("high side on in brake");
    a_ov_gates_off: assert property (bridgeASupplyHigh [*8] |=> allOff)
        else $error("gates on during overvoltage");
    a_ot_gates_off: assert property (overTempDetect [*8] |=> allOff)
        else $error("gates on during overtemperature");
    a_uv_all_off: assert property (
        uvDetect [*8] |=> allOff && !linkDataOutEn)
        else $error("outputs active in undervoltage");
    a_so_released: assert property (linkSelectN [*6] |-> !linkDataOutEn)
        else $error("serial output driven while deselected");
endmodule

bind bmfc_top bmfc_chk u_chk (.clk, .arst_n, .modePin, .modeSelectPin, .uvDetect,
    .bridgeASupplyHigh, .overTempDetect, .linkSelectN, .linkDataOutEn, .highSideOn, .lowSideOn);

// ### verification/bmfc_link_master.sv
`timescale 1ns/1ps
module bmfc_link_master (
    output logic      linkClk,
    output logic      linkSelectN,
    output logic      linkDataIn,
    input  wire logic linkDataOut
);
    // Idle: select high, clock and data at their pull-down level
    initial {linkClk, linkSelectN, linkDataIn} = 3'b010;
    // One 16-bit frame, MSB first, 800 ns clock that runs only inside it
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        rx = 16'h0;
        #25;
        linkSelectN = 1'b0;
        #400;
        for (int i = 15; i >= 0; i--) begin
            linkClk = 1'b1;
            linkDataIn = tx[i];
            #390;
            rx[i] = linkDataOut;
            #10;
            linkClk = 1'b0;
            #400;
        end
        linkSelectN = 1'b1;
        linkDataIn = 1'b0;
    endtask
endmodule

// ### verification/bmfc_tb_top.sv
`timescale 1ns/1ps
module bmfc_tb_top
    import bmfc_pkg::*;
;
    logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
    logic        linkClk, linkSelectN, linkDataIn, linkDataOut, linkDataOutEn;
    logic        modePin, modeSelectPin, uvDetect, bridgeASupplyHigh, overTempDetect;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, trOn;
    logic [11:0] overCurrentDetect, cmd, prev;
    logic [5:0]  highSideOn, lowSideOn;
    logic [15:0] rx;
    int          miscompares, compares;
    bmfc_top dut (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .linkClk, .linkSelectN, .linkDataIn, .linkDataOut, .linkDataOutEn, .modePin,
        .modeSelectPin, .uvDetect, .bridgeASupplyHigh, .overTempDetect, .overCurrentDetect,
        .highSideOn, .lowSideOn);
    bmfc_link_master lm (.linkClk, .linkSelectN, .linkDataIn, .linkDataOut);
    // Clock and transistor view (even index high side, odd low side)
    initial clk = 1'b0;
    always #50 clk = ~clk;
    always_comb begin
        trOn = '0;
        for (int k = 0; k < HB_COUNT; k++) begin
            trOn[2*k] = highSideOn[k];
            trOn[2*k+1] = lowSideOn[k];
        end
    end
    // Expected transistor states: both sides commanded gives both off
    function automatic logic [31:0] gates(input logic [11:0] c);
        for (int k = 0; k < HB_COUNT; k++) begin
            if (c[2*k] && c[2*k+1]) begin
                c[2*k+:2] = 2'b00;
            end
        end
        return {20'h0, c};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // APB transfer: setup, then access held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic frame(input logic [2:0] ctl, input logic [11:0] c, input logic b0);
        lm.xfer({ctl, c, b0}, rx);
        tick(24);
    endtask
    // Main sequence
    initial begin
        {arst_n, psel, penable, pwrite, paddr, pwdata, uvDetect} = '0;
        {bridgeASupplyHigh, overTempDetect, overCurrentDetect, modeSelectPin} = '0;
        {modePin, miscompares, compares, prev} = '0;
        modePin = 1'b1;
        void'($urandom(19558));
        tick(16);
        arst_n <= 1'b1;
        tick(8);
        rd_chk(REG_STATUS, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, REG_DEAD, 32'h0);
        rd_chk(REG_DEAD, 32'h1);
        apb(1'b1, REG_DEAD, 32'hA);
        rd_chk(REG_DEAD, 32'hA);
        $display("registers done");
        for (int i = 0; i < 6; i++) begin
            cmd = (i == 0) ? 12'hFFF : 12'($urandom);
            frame(3'b000, cmd, 1'b0);
            chk({16'h0, rx}, gates(prev) << 1);
            chk(trOn, gates(cmd));
            rd_chk(REG_STATUS, gates(cmd) << 1);
            prev = cmd;
        end
        $display("commands done");
        frame(3'b000, 12'h001, 1'b0);
        overCurrentDetect <= 12'h001;
        tick(12);
        chk(trOn, 32'h0);
        overCurrentDetect <= 12'h004;
        tick(12);
        rd_chk(REG_STATUS, 32'h2000);
        frame(3'b001, 12'h004, 1'b0);
        chk(trOn, 32'h0);
        overCurrentDetect <= 12'h000;
        tick(12);
        frame(3'b001, 12'h004, 1'b0);
        rd_chk(REG_STATUS, 32'h8);
        $display("overcurrent done");
        for (int f = 0; f < 2; f++) begin
            bridgeASupplyHigh <= (f == 0);
            overTempDetect <= (f == 1);
            tick(12);
            chk(trOn, 32'h0);
            bridgeASupplyHigh <= 1'b0;
            overTempDetect <= 1'b0;
            tick(24);
            rd_chk(REG_STATUS, (32'h8000 >> f) | 32'h8);
            frame(f ? 3'b010 : 3'b100, 12'h004, 1'b0);
            rd_chk(REG_STATUS, 32'h8);
        end
        overTempDetect <= 1'b1;
        tick(12);
        overTempDetect <= 1'b0;
        frame(3'b100, 12'h555, 1'b1);
        rd_chk(REG_STATUS, 32'h0);
        $display("faults done");
        frame(3'b000, 12'h001, 1'b0);
        {modePin, modeSelectPin} <= 2'b01;
        tick(24);
        chk(trOn, 32'hAAA);
        modePin <= 1'b1;
        tick(24);
        chk(trOn, 32'h1);
        frame(3'b000, 12'h004, 1'b0);
        chk(trOn, 32'h1);
        frame(3'b000, 12'h004, 1'b0);
        chk(trOn, 32'h4);
        modePin <= 1'b0;
        tick(24);
        fork
            frame(3'b000, 12'h010, 1'b0);
            begin
                tick(60);
                modePin <= 1'b1;
            end
        join
        chk(trOn, 32'h4);
        frame(3'b000, 12'h010, 1'b0);
        chk(trOn, 32'h10);
        $display("brake done");
        {modePin, modeSelectPin} <= 2'b00;
        bridgeASupplyHigh <= 1'b1;
        tick(24);
        chk(trOn, 32'h0);
        bridgeASupplyHigh <= 1'b0;
        frame(3'b000, 12'h040, 1'b0);
        modePin <= 1'b1;
        tick(24);
        rd_chk(REG_STATUS, 32'h0);
        $display("standby done");
        frame(3'b000, 12'h100, 1'b0);
        chk(trOn, 32'h100);
        apb(1'b1, REG_DEAD, 32'h5);
        uvDetect <= 1'b1;
        tick(12);
        chk(trOn, 32'h0);
        uvDetect <= 1'b0;
        tick(24);
        rd_chk(REG_DEAD, 32'hA);
        rd_chk(REG_STATUS, 32'h0);
        $display("undervoltage done");
        tally_and_finish();
    end
endmodule
